/* hw/opaddr_pkg.sv */
package opaddr_pkg;
   localparam int RF_AW = 12;
   localparam int PM_AW = 16;
   localparam int BYTE_W = 8;
   localparam int NIB_W = 4;
   localparam logic [7:0] ESC_LO = 8'he0;
   localparam logic [7:0] ESC_HI = 8'hef;
   localparam logic [3:0] PAIR_EVEN_MASK = 4'he;
   localparam logic [11:0] RF_RST = 12'h000;
   localparam logic [15:0] PM_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // operand forms
   typedef enum logic [3:0] {
      FORM_WREG = 4'h0,
      FORM_WPAIR = 4'h1,
      FORM_REG = 4'h2,
      FORM_RPAIR = 4'h3,
      FORM_IND_WREG = 4'h4,
      FORM_IND_WPAIR = 4'h5,
      FORM_IND_REG = 4'h6,
      FORM_IND_PAIR_JUMP = 4'h7,
      FORM_INDEXED = 4'h8,
      FORM_IMMEDIATE = 4'h9,
      FORM_DIRECT = 4'ha,
      FORM_RELATIVE = 4'hb,
      FORM_DECREMENT_JUMP_NONZERO = 4'hc
   } form_t;
   // condition field codes
   localparam logic [3:0] CC_F = 4'h0;
   localparam logic [3:0] CC_LT = 4'h1;
   localparam logic [3:0] CC_LE = 4'h2;
   localparam logic [3:0] CC_ULE = 4'h3;
   localparam logic [3:0] CC_OV = 4'h4;
   localparam logic [3:0] CC_MI = 4'h5;
   localparam logic [3:0] CC_EQ = 4'h6;
   localparam logic [3:0] CC_CY = 4'h7;
   localparam logic [3:0] CC_T = 4'h8;
   localparam logic [3:0] CC_GE = 4'h9;
   localparam logic [3:0] CC_GT = 4'ha;
   localparam logic [3:0] CC_UGT = 4'hb;
   localparam logic [3:0] CC_NOV = 4'hc;
   localparam logic [3:0] CC_PL = 4'hd;
   localparam logic [3:0] CC_NE = 4'he;
   localparam logic [3:0] CC_NC = 4'hf;
endpackage

/* hw/condition_test.sv */
`timescale 1ns/10ps
module condition_test
   import opaddr_pkg::*;
(
   // field and flags
   input wire logic [3:0] condition_field_in,
   input wire logic carry_in,
   input wire logic zero_in,
   input wire logic sign_in,
   input wire logic overflow_in,
   // result
   output logic pass_out
);
   always_comb begin
      case (condition_field_in)
         CC_F: pass_out = 1'b0;
         CC_LT: pass_out = sign_in ^ overflow_in;
         CC_LE: pass_out = zero_in | (sign_in ^ overflow_in);
         CC_ULE: pass_out = carry_in | zero_in;
         CC_OV: pass_out = overflow_in;
         CC_MI: pass_out = sign_in;
         CC_EQ: pass_out = zero_in;
         CC_CY: pass_out = carry_in;
         CC_T: pass_out = 1'b1;
         CC_GE: pass_out = ~(sign_in ^ overflow_in);
         CC_GT: pass_out = ~(zero_in | (sign_in ^ overflow_in));
         CC_UGT: pass_out = ~(carry_in | zero_in);
         CC_NOV: pass_out = ~overflow_in;
         CC_PL: pass_out = ~sign_in;
         CC_NE: pass_out = ~zero_in;
         CC_NC: pass_out = ~carry_in;
         default: pass_out = 1'b0;
      endcase
   end
endmodule

/* hw/operand_address_generation.sv */
`timescale 1ns/10ps
module operand_address_generation
   import opaddr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys_in,
   input wire logic rst_in,
   // request
   input wire logic req_valid_in,
   input wire form_t form_in,
   input wire logic [7:0] register_pointer_in,
   input wire logic [7:0] operand_in,
   input wire logic [7:0] base_in,
   input wire logic [7:0] fetched_byte_in,
   input wire logic [15:0] fetched_word_in,
   input wire logic pair_to_memory_in,
   input wire logic [7:0] immediate_operand_in,
   input wire logic [15:0] direct_jump_address_in,
   input wire logic [7:0] relative_jump_offset_in,
   input wire logic [15:0] next_pc_in,
   input wire logic [3:0] condition_field_in,
   input wire logic use_condition_in,
   input wire logic decrement_jump_nonzero_count_nonzero_in,
   // flags
   input wire logic carry_in,
   input wire logic zero_in,
   input wire logic sign_in,
   input wire logic overflow_in,
   // result
   output logic valid_out,
   output logic [11:0] rf_addr_out,
   output logic rf_addr_valid_out,
   output logic [15:0] pm_addr_out,
   output logic pm_addr_valid_out,
   output logic [7:0] immediate_operand_out,
   output logic imm_valid_out,
   output logic [15:0] pc_out,
   output logic pc_load_out,
   output logic odd_pair_out
);
   logic cond_pass;
   logic [3:0] rp_lo;
   logic [3:0] rp_hi;
   logic [11:0] wreg_addr;
   logic [11:0] reg8_addr;
   logic [7:0] idx_sum;
   logic [15:0] rel_target;
   logic [15:0] rel_ext;
   logic esc_hit;
   logic jump_ok;
   logic [3:0] pair_even;
   logic valid_d, valid_q;
   logic [11:0] rf_d, rf_q;
   logic rfv_d, rfv_q;
   logic [15:0] pm_d, pm_q;
   logic pmv_d, pmv_q;
   logic [7:0] imm_d, imm_q;
   logic immv_d, immv_q;
   logic [15:0] pc_d, pc_q;
   logic pcl_d, pcl_q;
   logic odd_d, odd_q;

   condition_test u_cond (
      .condition_field_in(condition_field_in),
      .carry_in(carry_in),
      .zero_in(zero_in),
      .sign_in(sign_in),
      .overflow_in(overflow_in),
      .pass_out(cond_pass)
   );

   // page in the low half of the pointer, working group in the high half
   assign rp_lo = register_pointer_in[3:0];
   assign rp_hi = register_pointer_in[7:4];
   // working register number sits in the operand low nibble
   assign wreg_addr = {rp_lo, rp_hi, operand_in[3:0]};
   assign pair_even = operand_in[3:0] & PAIR_EVEN_MASK;
   // escape range redirects into the current working group
   assign esc_hit = (operand_in >= ESC_LO) && (operand_in <= ESC_HI);
   always_comb begin
      if (esc_hit) begin
         reg8_addr = {rp_lo, rp_hi, operand_in[3:0]};
      end else begin
         reg8_addr = {rp_lo, operand_in};
      end
   end
   // carry out dropped so the page nibble is never disturbed
   assign idx_sum = 8'(base_in + fetched_byte_in);
   // sign extension keeps backward jumps backward across the whole counter
   assign rel_ext = {{(PM_AW - BYTE_W){relative_jump_offset_in[BYTE_W-1]}},
                     relative_jump_offset_in};
   assign rel_target = 16'(next_pc_in + rel_ext);

   // a jump is taken with no condition or with a passing flag test
   assign jump_ok = ~use_condition_in | cond_pass;

   // accept strobe follows the request by one edge
   always_comb begin
      valid_d = req_valid_in;
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         valid_q <= 1'b0;
      end else begin
         valid_q <= valid_d;
      end
   end

   // file address holds between requests, only the strobe pulses
   always_comb begin
      rf_d = rf_q;
      rfv_d = 1'b0;
      if (req_valid_in) begin
         case (form_in)
            FORM_WREG: begin
               rf_d = wreg_addr;
               rfv_d = 1'b1;
            end
            FORM_WPAIR: begin
               // odd pair number forced even, flagged on odd_pair_out from the operand low bit
               rf_d = {rp_lo, rp_hi, pair_even};
               rfv_d = 1'b1;
            end
            FORM_REG, FORM_RPAIR: begin
               rf_d = reg8_addr;
               rfv_d = 1'b1;
            end
            FORM_IND_WREG, FORM_IND_REG: begin
               rf_d = {rp_lo, fetched_byte_in};
               rfv_d = 1'b1;
            end
            FORM_IND_WPAIR: begin
               // the memory view of the pair goes to the program address group
               if (!pair_to_memory_in) begin
                  rf_d = fetched_word_in[RF_AW-1:0];
                  rfv_d = 1'b1;
               end
            end
            FORM_INDEXED: begin
               rf_d = {rp_lo, idx_sum};
               rfv_d = 1'b1;
            end
            default: begin
               rfv_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         rf_q <= RF_RST;
         rfv_q <= 1'b0;
      end else begin
         rf_q <= rf_d;
         rfv_q <= rfv_d;
      end
   end

   // odd pair flag
   always_comb begin
      odd_d = 1'b0;
      if (req_valid_in && form_in == FORM_WPAIR) begin
         odd_d = operand_in[0];
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         odd_q <= 1'b0;
      end else begin
         odd_q <= odd_d;
      end
   end

   // program memory address from a pair
   always_comb begin
      pm_d = pm_q;
      pmv_d = 1'b0;
      if (req_valid_in && form_in == FORM_IND_WPAIR && pair_to_memory_in) begin
         pm_d = fetched_word_in;
         pmv_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pm_q <= PM_RST;
         pmv_q <= 1'b0;
      end else begin
         pm_q <= pm_d;
         pmv_q <= pmv_d;
      end
   end

   // immediate byte
   always_comb begin
      imm_d = imm_q;
      immv_d = 1'b0;
      if (req_valid_in && form_in == FORM_IMMEDIATE) begin
         imm_d = immediate_operand_in;
         immv_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         imm_q <= BYTE_RST;
         immv_q <= 1'b0;
      end else begin
         imm_q <= imm_d;
         immv_q <= immv_d;
      end
   end

   // jump target; it moves even when the jump is not taken
   always_comb begin
      pc_d = pc_q;
      if (req_valid_in) begin
         case (form_in)
            FORM_IND_PAIR_JUMP: begin
               pc_d = fetched_word_in;
            end
            FORM_DIRECT: begin
               pc_d = direct_jump_address_in;
            end
            FORM_RELATIVE: begin
               pc_d = rel_target;
            end
            FORM_DECREMENT_JUMP_NONZERO: begin
               pc_d = rel_target;
            end
            default: begin
               pc_d = pc_q;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pc_q <= PM_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   // load strobe; the count test stands in for the flag test on a decrement jump
   always_comb begin
      pcl_d = 1'b0;
      if (req_valid_in) begin
         case (form_in)
            FORM_IND_PAIR_JUMP, FORM_DIRECT: begin
               pcl_d = jump_ok;
            end
            FORM_RELATIVE: begin
               pcl_d = jump_ok;
            end
            FORM_DECREMENT_JUMP_NONZERO: begin
               pcl_d = decrement_jump_nonzero_count_nonzero_in;
            end
            default: begin
               pcl_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or posedge rst_in) begin
      if (rst_in) begin
         pcl_q <= 1'b0;
      end else begin
         pcl_q <= pcl_d;
      end
   end

   assign valid_out = valid_q;
   assign rf_addr_out = rf_q;
   assign rf_addr_valid_out = rfv_q;
   assign pm_addr_out = pm_q;
   assign pm_addr_valid_out = pmv_q;
   assign immediate_operand_out = imm_q;
   assign imm_valid_out = immv_q;
   assign pc_out = pc_q;
   assign pc_load_out = pcl_q;
   assign odd_pair_out = odd_q;
endmodule

/* sim/opaddr_checker.sv */
`timescale 1ns/10ps
module opaddr_checker
   import opaddr_pkg::*;
(
   // request
   input wire logic clk_sys_in,
   input wire logic rst_in,
   input wire logic req_valid_in,
   input wire form_t form_in,
   input wire logic [7:0] register_pointer_in,
   input wire logic [7:0] operand_in,
   input wire logic [7:0] base_in,
   input wire logic [7:0] fetched_byte_in,
   input wire logic [7:0] immediate_operand_in,
   input wire logic [15:0] direct_jump_address_in,
   input wire logic [7:0] relative_jump_offset_in,
   input wire logic [15:0] next_pc_in,
   input wire logic use_condition_in,
   // result
   input wire logic [11:0] rf_addr_out,
   input wire logic [7:0] immediate_operand_out,
   input wire logic [15:0] pc_out,
   input wire logic pc_load_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);
   wire [7:0] p = register_pointer_in;
   wire [7:0] o = operand_in;
   wire r = req_valid_in;
   wire esc = o >= ESC_LO && o <= ESC_HI;
   wire [11:0] e_w = {p[3:0], p[7:4], o[3:0]};
   wire [11:0] e_pr = {p[3:0], p[7:4], o[3:1], 1'b0};
   wire [11:0] e_n = {p[3:0], o};
   wire [11:0] e_rp = esc ? e_w : e_n;
   wire [11:0] e_i = {p[3:0], fetched_byte_in};
   wire [7:0] sum = base_in + fetched_byte_in;
   wire [11:0] e_x = {p[3:0], sum};
   wire [7:0] ro = relative_jump_offset_in;
   wire [15:0] e_j = next_pc_in + {{8{ro[7]}}, ro};
   // all checks look one edge past the request, the fixed answer latency
   a_wreg_addr: assert property (r && form_in == FORM_WREG |=> rf_addr_out == $past(e_w))
      else $error("working register address wrong");
   a_wpair_even: assert property (r && form_in == FORM_WPAIR |=> rf_addr_out == $past(e_pr))
      else $error("working pair address wrong");
   a_reg_normal: assert property (r && form_in == FORM_REG && !esc |=> rf_addr_out == $past(e_n))
      else $error("register address wrong");
   a_reg_escaped: assert property (r && form_in == FORM_REG && esc |=> rf_addr_out == $past(e_w))
      else $error("escaped register address wrong");
   a_rpair_map: assert property (r && form_in == FORM_RPAIR |=> rf_addr_out == $past(e_rp))
      else $error("register pair address wrong");
   a_ind_byte: assert property (r && (form_in == FORM_IND_WREG || form_in == FORM_IND_REG)
      |=> rf_addr_out == $past(e_i))
      else $error("indirect address wrong");
   a_index_wrap: assert property (r && form_in == FORM_INDEXED |=> rf_addr_out == $past(e_x))
      else $error("indexed address wrong");
   a_imm_pass: assert property (r && form_in == FORM_IMMEDIATE
      |=> immediate_operand_out == $past(immediate_operand_in))
      else $error("immediate wrong");
   a_direct_load: assert property (r && form_in == FORM_DIRECT && !use_condition_in
      |=> pc_load_out && pc_out == $past(direct_jump_address_in))
      else $error("direct jump wrong");
   a_rel_target: assert property (r && form_in == FORM_RELATIVE && !use_condition_in
      |=> pc_load_out && pc_out == $past(e_j))
      else $error("relative target wrong");
endmodule

/* sim/operand_address_generation_tb.sv */
`timescale 1ns/10ps
module operand_address_generation_tb;
   import opaddr_pkg::*;
   logic clk_sys_in = 0, rst_in = 1, req_valid_in = 0, pair_to_memory_in = 0;
   logic use_condition_in = 0, decrement_jump_nonzero_count_nonzero_in = 0;
   logic carry_in = 0, zero_in = 0, sign_in = 0, overflow_in = 0;
   form_t form_in = FORM_WREG;
   logic [7:0] register_pointer_in = 0, operand_in = 0, base_in = 0, fetched_byte_in = 0;
   logic [7:0] immediate_operand_in = 0, relative_jump_offset_in = 0, immediate_operand_out;
   logic [15:0] fetched_word_in = 0, direct_jump_address_in = 0, next_pc_in = 0;
   logic [3:0] condition_field_in = 0;
   logic valid_out, rf_addr_valid_out, pm_addr_valid_out, imm_valid_out, pc_load_out;
   logic odd_pair_out;
   logic [11:0] rf_addr_out;
   logic [15:0] pm_addr_out, pc_out;
   int n_fail = 0, samples_checked = 0, cyc = 0;
   operand_address_generation dut_u (.*);
   always #2 clk_sys_in = ~clk_sys_in;
   task chk(input string n, input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // request stays raised, so every edge is a back-to-back request
   task go(input form_t f);
      form_in = f;
      @(posedge clk_sys_in);
      #1;
   endtask
   task t_wreg;
      register_pointer_in = 8'h21;
      operand_in = 8'h05;
      go(FORM_WREG);
      chk("rf", rf_addr_out, 16'h0125);
      chk("rfv", rf_addr_valid_out, 16'h0001);
      chk("valid", valid_out, 16'h0001);
      operand_in = 8'h07;
      go(FORM_WPAIR);
      chk("rf", rf_addr_out, 16'h0126);
      chk("odd", odd_pair_out, 16'h0001);
      operand_in = 8'h0c;
      go(FORM_WPAIR);
      chk("rf", rf_addr_out, 16'h012c);
      chk("odd", odd_pair_out, 16'h0000);
   endtask
   task t_reg;
      logic [7:0] v[4];
      logic [15:0] e;
      v = '{8'hdf, 8'he0, 8'hef, 8'hf0};
      register_pointer_in = 8'h3a;
      for (int i = 0; i < 4; i++) begin
         operand_in = v[i];
         e = (v[i][7:4] == 4'he) ? {8'h0a, 4'h3, v[i][3:0]} : {8'h0a, v[i]};
         go(FORM_REG);
         chk("rf reg", rf_addr_out, e);
         go(FORM_RPAIR);
         chk("rf pair", rf_addr_out, e);
      end
   endtask
   task t_ind;
      fetched_byte_in = 8'h9c;
      go(FORM_IND_WREG);
      chk("rf", rf_addr_out, 16'h0a9c);
      fetched_byte_in = 8'h5e;
      go(FORM_IND_REG);
      chk("rf", rf_addr_out, 16'h0a5e);
      fetched_word_in = 16'h1abc;
      go(FORM_IND_WPAIR);
      chk("rf", rf_addr_out, 16'h0abc);
      chk("pmv", pm_addr_valid_out, 16'h0000);
      pair_to_memory_in = 1;
      go(FORM_IND_WPAIR);
      chk("pm", pm_addr_out, 16'h1abc);
      chk("pmv", pm_addr_valid_out, 16'h0001);
      chk("rfv", rf_addr_valid_out, 16'h0000);
      fetched_word_in = 16'hbeef;
      go(FORM_IND_PAIR_JUMP);
      chk("pc", pc_out, 16'hbeef);
      chk("load", pc_load_out, 16'h0001);
      base_in = 8'hf0;
      fetched_byte_in = 8'h20;
      go(FORM_INDEXED);
      chk("rf", rf_addr_out, 16'h0a10);
      base_in = 8'h10;
      fetched_byte_in = 8'hf0;
      go(FORM_INDEXED);
      chk("rf", rf_addr_out, 16'h0a00);
      immediate_operand_in = 8'hff;
      go(FORM_IMMEDIATE);
      chk("imm", immediate_operand_out, 16'h00ff);
      chk("immv", imm_valid_out, 16'h0001);
   endtask
   // idle cycle: strobes drop, data holds; then a reset in mid-run clears all
   task t_idle;
      req_valid_in = 0;
      @(posedge clk_sys_in);
      #1;
      chk("valid", valid_out, 16'h0000);
      chk("rfv", rf_addr_valid_out, 16'h0000);
      chk("pmv", pm_addr_valid_out, 16'h0000);
      chk("immv", imm_valid_out, 16'h0000);
      chk("load", pc_load_out, 16'h0000);
      chk("rf hold", rf_addr_out, 16'h0a00);
      chk("pm hold", pm_addr_out, 16'h1abc);
      chk("imm hold", immediate_operand_out, 16'h00ff);
      rst_in = 1;
      #1;
      chk("rst rf", rf_addr_out, 16'h0000);
      chk("rst pc", pc_out, 16'h0000);
      chk("rst imm", immediate_operand_out, 16'h0000);
      @(posedge clk_sys_in);
      #1;
      rst_in = 0;
      req_valid_in = 1;
   endtask
   task t_jump;
      direct_jump_address_in = 16'hffff;
      go(FORM_DIRECT);
      chk("pc", pc_out, 16'hffff);
      relative_jump_offset_in = 8'h80;
      go(FORM_RELATIVE);
      chk("pc", pc_out, 16'hff80);
      relative_jump_offset_in = 8'h7f;
      next_pc_in = 16'hfff0;
      go(FORM_RELATIVE);
      chk("pc", pc_out, 16'h006f);
      decrement_jump_nonzero_count_nonzero_in = 1;
      go(form_t'(4'hc));
      chk("load", pc_load_out, 16'h0001);
      chk("pc", pc_out, 16'h006f);
      decrement_jump_nonzero_count_nonzero_in = 0;
      go(form_t'(4'hc));
      chk("load", pc_load_out, 16'h0000);
   endtask
   function automatic logic cond_exp(input logic [3:0] k, input logic [3:0] f);
      logic [7:0] t;
      t = {f[3], f[2], f[1], f[0], f[3] | f[2], f[2] | (f[1] ^ f[0]), f[1] ^ f[0], 1'b0};
      return t[k[2:0]] ^ k[3];
   endfunction
   task t_cond;
      use_condition_in = 1;
      for (int k = 0; k < 16; k++) begin
         for (int f = 0; f < 16; f++) begin
            condition_field_in = 4'(k);
            {carry_in, zero_in, sign_in, overflow_in} = 4'(f);
            go(FORM_RELATIVE);
            chk("taken", pc_load_out, 16'(cond_exp(4'(k), 4'(f))));
         end
      end
      go(FORM_DIRECT);
      chk("load", pc_load_out, 16'h0000);
      condition_field_in = CC_T;
      go(FORM_IND_PAIR_JUMP);
      chk("load", pc_load_out, 16'h0001);
      go(form_t'(4'hd));
      chk("valid", valid_out, 16'h0001);
      chk("load", pc_load_out, 16'h0000);
      chk("rfv", rf_addr_valid_out, 16'h0000);
   endtask
   task results;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         results;
      end
   end
   initial begin
      repeat (20) @(posedge clk_sys_in);
      #1;
      rst_in = 0;
      req_valid_in = 1;
      t_wreg;
      t_reg;
      t_ind;
      t_idle;
      t_jump;
      t_cond;
      results;
   end
endmodule
bind operand_address_generation opaddr_checker chk_u (.*);
